// ### hdl/gp_port.sv
/*
  gp_port: one sixteen-pin general purpose port: configuration, data, bit set and
  clear, configuration lock and alternate function selection registers, plus the
  input capture and the alternate function input routing.
  assumes a single-cycle register master on clk; pins arrive asynchronously and the
  pin wire is resolved outside from pinOut and pinOe.
*/
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps

// What this block does
// - four config registers, input and output data, a bit set/clear and a bit clear register
// - lock register and two alternate function selects when the port has them
// - alternate function selects kept by parameter for larger variant ports
// - push-pull or open-drain drive, each with optional weak pull-up or down
// - pin driven from output data or from the selected peripheral output
// - pin level lands in input data and feeds the selected peripheral input
// - two-bit speed per pin, used only in output and alternate modes
// - each pin picks one of sixteen alternate functions
// - output can follow a software toggle on every cycle
// - lock sequence freezes configuration of the port pins set in its mask
// - word, half-word and byte accesses; software keeps to these sizes
// - set/clear registers change chosen output bits in one single write
// - mode 01 is output; type bit picks push-pull or open-drain
// - mode 10 is alternate function with the same type, speed and pull
// - pins independent; 00 input, 11 analog ignore type and speed
// - pull 00 none, 01 up, 10 down, 11 behaves as none
// - set beats clear on the same bit; zero bits change nothing
// - input data samples the pins every clock cycle
// - locked pins keep mode, type, speed, pull and function until reset
// - after reset function 0 and pins in floating input
module gp_port
  import gp_pkg::*;
#(
  parameter bit HAS_LOCK = 1'b1,
  parameter bit HAS_ALTFUNC = 1'b1,
  parameter logic [31:0] MODE_RESET = RESET_MODE,
  parameter logic [31:0] SPEED_RESET = RESET_SPEED,
  parameter logic [31:0] PULL_RESET = RESET_PULL
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wrData,
  input wire logic [3:0] wrByteEn,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [31:0] rdData,
  input wire logic [PIN_COUNT-1:0] pinIn,
  output logic [PIN_COUNT-1:0] pinOut,
  output logic [PIN_COUNT-1:0] pinOe,
  output logic [PIN_COUNT-1:0] pullUpEn,
  output logic [PIN_COUNT-1:0] pullDownEn,
  output logic [31:0] speedOut,
  output logic [PIN_COUNT-1:0] analogEn,
  input wire logic [PIN_COUNT*AF_COUNT-1:0] altfuncOut,
  output logic [PIN_COUNT*AF_COUNT-1:0] altfuncIn,
  output logic configLocked
);

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] gpMerge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0] be
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // widen a per-pin lock mask onto two-bit fields
  function automatic logic [31:0] gpExpand2(input logic [15:0] m);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < PIN_COUNT; i++) begin
      r[2*i +: 2] = {2{m[i]}};
    end
    return r;
  endfunction

  // widen eight pins of lock mask onto four-bit fields
  function automatic logic [31:0] gpExpand4(input logic [7:0] m);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < AF_LOW_PINS; i++) begin
      r[AF_W*i +: AF_W] = {AF_W{m[i]}};
    end
    return r;
  endfunction

  // locked bits keep their value, the rest take the merged write
  function automatic logic [31:0] gpGuarded(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0] be,
    input logic [31:0] frozen
  );
    return (old & frozen) | (gpMerge(old, nw, be) & ~frozen);
  endfunction

  gp_cfg_if cfg();

  logic [31:0] pinMode;
  logic [15:0] outputType;
  logic [31:0] outputSpeed;
  logic [31:0] pullSelect;
  logic [31:0] altfuncLow;
  logic [31:0] altfuncHigh;
  logic [15:0] outputData;
  logic [15:0] inputData;
  logic [15:0] pinSync;
  logic [15:0] lockMask;
  logic [15:0] lockKey;
  logic lockKeyBit;
  gp_lock_state_t lockState;
  gp_lock_state_t next_lockState;
  logic [31:0] next_rdData;
  logic [31:0] frozen2;
  logic [31:0] frozenLow;
  logic [31:0] frozenHigh;
  logic [15:0] setBits;
  logic [15:0] clearBits;
  logic [31:0] laneWord, typeWord, odrWord;

  // write decodes
  logic wrMode;
  logic wrType;
  logic wrSpeed;
  logic wrPull;
  logic wrOdr;
  logic wrSetClear;
  logic wrClear;
  logic wrLock;
  logic wrAfLow;
  logic wrAfHigh;

  assign wrMode = wrEn && addr == OFS_PIN_MODE;
  assign wrType = wrEn && addr == OFS_OUTPUT_TYPE;
  assign wrSpeed = wrEn && addr == OFS_OUTPUT_SPEED;
  assign wrPull = wrEn && addr == OFS_PULL_SELECT;
  assign wrOdr = wrEn && addr == OFS_OUTPUT_DATA;
  assign wrSetClear = wrEn && addr == OFS_BIT_SET_CLEAR;
  assign wrClear = wrEn && addr == OFS_BIT_CLEAR;
  assign wrLock = wrEn && addr == OFS_CONFIG_LOCK && HAS_LOCK;
  assign wrAfLow = wrEn && addr == OFS_ALTFUNC_LOW && HAS_ALTFUNC;
  assign wrAfHigh = wrEn && addr == OFS_ALTFUNC_HIGH && HAS_ALTFUNC;
  assign laneWord = gpMerge(RESET_ZERO, wrData, wrByteEn);
  assign odrWord = gpMerge({16'h0000, outputData}, wrData, wrByteEn);
  assign typeWord = gpGuarded({16'h0000, outputType}, wrData, wrByteEn, {16'h0000, lockMask});

  // frozen masks for each configuration register layout
  assign frozen2 = gpExpand2(lockMask);
  assign frozenLow = gpExpand4(lockMask[7:0]);
  assign frozenHigh = gpExpand4(lockMask[15:8]);

  // mode, type, speed and pull registers; byte lanes honoured on every write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinMode <= MODE_RESET;
      outputType <= 16'h0000;
      outputSpeed <= SPEED_RESET;
      pullSelect <= PULL_RESET;
    end else begin
      if (wrMode) begin
        pinMode <= gpGuarded(pinMode, wrData, wrByteEn, frozen2);
      end
      if (wrType) begin
        outputType <= typeWord[15:0];
      end
      if (wrSpeed) begin
        outputSpeed <= gpGuarded(outputSpeed, wrData, wrByteEn, frozen2);
      end
      if (wrPull) begin
        pullSelect <= gpGuarded(pullSelect, wrData, wrByteEn, frozen2);
      end
    end
  end

  // alternate function selects; absent on ports built without them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      altfuncLow <= RESET_ZERO;
      altfuncHigh <= RESET_ZERO;
    end else begin
      if (wrAfLow) begin
        altfuncLow <= gpGuarded(altfuncLow, wrData, wrByteEn, frozenLow);
      end
      if (wrAfHigh) begin
        altfuncHigh <= gpGuarded(altfuncHigh, wrData, wrByteEn, frozenHigh);
      end
    end
  end

  // set and clear requests, gated by byte lane so a narrow write touches only its half
  always_comb begin
    setBits = 16'h0000;
    clearBits = 16'h0000;
    if (wrSetClear) begin
      setBits = laneWord[15:0];
      clearBits = laneWord[31:16];
    end
    if (wrClear) begin
      clearBits = laneWord[15:0];
    end
  end

  // output data: one write updates it, so a toggle per write reaches the pin two edges later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      outputData <= 16'h0000;
    end else if (wrOdr) begin
      outputData <= odrWord[15:0];
    end else if (wrSetClear || wrClear) begin
      // single write, no read-modify-write window for an interrupt to land in
      outputData <= (outputData & ~clearBits) | setBits;
    end
  end

  // pins cross into clk through two flops; the second is the input data register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinSync <= 16'h0000;
      inputData <= 16'h0000;
    end else begin
      pinSync <= pinIn;
      inputData <= pinSync & ~analogEn;
    end
  end

  // lock sequence: word writes of key-set, key-clear, key-set with the same mask
  always_comb begin
    next_lockState = lockState;
    case (lockState)
      LK_IDLE: begin
        if (wrLock && wrByteEn == BYTE_EN_WORD && wrData[LOCK_KEY_BIT]) begin
          next_lockState = LK_ONE;
        end
      end
      LK_ONE: begin
        if (wrLock) begin
          if (wrByteEn == BYTE_EN_WORD && !wrData[LOCK_KEY_BIT] &&
              wrData[15:0] == lockKey) begin
            next_lockState = LK_ZERO;
          end else begin
            next_lockState = LK_IDLE;
          end
        end
      end
      LK_ZERO: begin
        if (wrLock) begin
          if (wrByteEn == BYTE_EN_WORD && wrData[LOCK_KEY_BIT] &&
              wrData[15:0] == lockKey) begin
            next_lockState = LK_DONE;
          end else begin
            next_lockState = LK_IDLE;
          end
        end
      end
      LK_DONE: begin
        next_lockState = LK_DONE; // only reset leaves the locked state
      end
      default: begin
        next_lockState = LK_IDLE;
      end
    endcase
  end

  // lock state and its captured mask
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lockState <= LK_IDLE;
      lockKey <= 16'h0000;
      lockMask <= 16'h0000;
      lockKeyBit <= 1'b0;
    end else begin
      lockState <= next_lockState;
      if (lockState == LK_IDLE && next_lockState == LK_ONE) begin
        lockKey <= wrData[15:0];
      end
      if (lockState != LK_DONE && next_lockState == LK_DONE) begin
        lockMask <= lockKey;
        lockKeyBit <= 1'b1;
      end
    end
  end

  assign configLocked = lockKeyBit;

  // read mux; unmapped and absent registers read as zero
  always_comb begin
    next_rdData = 32'h0000_0000;
    case (addr)
      OFS_PIN_MODE: next_rdData = pinMode;
      OFS_OUTPUT_TYPE: next_rdData = {16'h0000, outputType};
      OFS_OUTPUT_SPEED: next_rdData = outputSpeed;
      OFS_PULL_SELECT: next_rdData = pullSelect;
      OFS_INPUT_DATA: next_rdData = {16'h0000, inputData};
      OFS_OUTPUT_DATA: next_rdData = {16'h0000, outputData};
      OFS_CONFIG_LOCK: begin
        if (HAS_LOCK) begin
          next_rdData = {15'h0000, lockKeyBit, lockMask};
        end
      end
      OFS_ALTFUNC_LOW: begin
        if (HAS_ALTFUNC) begin
          next_rdData = altfuncLow;
        end
      end
      OFS_ALTFUNC_HIGH: begin
        if (HAS_ALTFUNC) begin
          next_rdData = altfuncHigh;
        end
      end
      default: begin
        next_rdData = 32'h0000_0000; // set/clear registers are write-only
      end
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData <= 32'h0000_0000;
    end else if (rdEn) begin
      rdData <= next_rdData;
    end else begin
      rdData <= 32'h0000_0000;
    end
  end

  // alternate function inputs: only the selected channel sees the pin level
  always_comb begin
    altfuncIn = '0;
    for (int i = 0; i < PIN_COUNT; i++) begin
      for (int f = 0; f < AF_COUNT; f++) begin
        altfuncIn[i*AF_COUNT + f] = inputData[i] &&
          (int'(cfg.altfuncSelect[i*AF_W +: AF_W]) == f);
      end
    end
  end

  // configuration carrier to the pad stage
  assign cfg.pinMode = pinMode;
  assign cfg.outputType = outputType;
  assign cfg.outputSpeed = outputSpeed;
  assign cfg.pullSelect = pullSelect;
  assign cfg.altfuncSelect = {altfuncHigh, altfuncLow};
  assign cfg.outputData = outputData;

  // output stage, registered so drive changes one edge after the data register
  gp_pad u_pad (
    .clk(clk),
    .rst(rst),
    .cfg(cfg.pad),
    .altfuncOut(altfuncOut),
    .pinOut(pinOut),
    .pinOe(pinOe),
    .pullUpEn(pullUpEn),
    .pullDownEn(pullDownEn),
    .speedOut(speedOut),
    .analogEn(analogEn)
  );

endmodule

// ### shared/gp_pkg.sv
/*
  gp_pkg: constants shared by the port top module, its pad stage and the bench
  models and checks: register offsets, field widths, mode and pull codes, reset values.
  assumes one port of sixteen pins behind a plain byte-addressed register port.
*/
package gp_pkg;

  // port geometry
  localparam int PIN_COUNT = 16;
  localparam int AF_COUNT = 16;
  localparam int MODE_W = 2;
  localparam int AF_W = 4;
  localparam int AF_LOW_PINS = 8;
  localparam int ADDR_W = 8;

  // register byte offsets, one aligned word each
  localparam logic [ADDR_W-1:0] OFS_PIN_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_TYPE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_SPEED = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PULL_SELECT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_INPUT_DATA = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_DATA = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_BIT_SET_CLEAR = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CONFIG_LOCK = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_ALTFUNC_LOW = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_ALTFUNC_HIGH = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_BIT_CLEAR = 8'h28;

  // pin mode field codes
  localparam logic [MODE_W-1:0] MODE_INPUT = 2'h0;
  localparam logic [MODE_W-1:0] MODE_OUTPUT = 2'h1;
  localparam logic [MODE_W-1:0] MODE_ALTFUNC = 2'h2;
  localparam logic [MODE_W-1:0] MODE_ANALOG = 2'h3;

  // pull select field codes, code 3 is reserved
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_UP = 2'h1;
  localparam logic [1:0] PULL_DOWN = 2'h2;

  // output type bit
  localparam logic OTYPE_OPEN_DRAIN = 1'b1;

  // lock register layout
  localparam int LOCK_KEY_BIT = 16;
  localparam logic [3:0] BYTE_EN_WORD = 4'hF;

  // reset values
  localparam logic [31:0] RESET_MODE = 32'h0000_0000;
  localparam logic [31:0] RESET_SPEED = 32'h0000_0000;
  localparam logic [31:0] RESET_PULL = 32'h0000_0000;
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;

  // lock sequencer states
  typedef enum logic [3:0] {
    LK_IDLE = 4'h1,
    LK_ONE = 4'h2,
    LK_ZERO = 4'h4,
    LK_DONE = 4'h8
  } gp_lock_state_t;

endpackage

// ### shared/gp_cfg_if.sv
/*
  gp_cfg_if: carrier of the live pin configuration from the register file to the
  pad stage. assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
interface gp_cfg_if;
  logic [31:0] pinMode;
  logic [15:0] outputType;
  logic [31:0] outputSpeed;
  logic [31:0] pullSelect;
  logic [63:0] altfuncSelect;
  logic [15:0] outputData;

  // register file drives, pad stage listens
  modport src (
    output pinMode,
    output outputType,
    output outputSpeed,
    output pullSelect,
    output altfuncSelect,
    output outputData
  );
  modport pad (
    input pinMode,
    input outputType,
    input outputSpeed,
    input pullSelect,
    input altfuncSelect,
    input outputData
  );
endinterface

// ### hdl/gp_pad.sv
/*
  gp_pad: per-pin output stage. turns the configuration into registered drive,
  output enable, pull enables, speed and analog switch controls.
  assumes the pin wire level is resolved outside from pinOut and pinOe.
*/
`timescale 1ns/1ps
module gp_pad
  import gp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  gp_cfg_if.pad cfg,
  input wire logic [PIN_COUNT*AF_COUNT-1:0] altfuncOut,
  output logic [PIN_COUNT-1:0] pinOut,
  output logic [PIN_COUNT-1:0] pinOe,
  output logic [PIN_COUNT-1:0] pullUpEn,
  output logic [PIN_COUNT-1:0] pullDownEn,
  output logic [31:0] speedOut,
  output logic [PIN_COUNT-1:0] analogEn
);

  // drive value and enable, registered so the pin never glitches on decode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinOut <= 16'h0000;
      pinOe <= 16'h0000;
    end else begin
      for (int i = 0; i < PIN_COUNT; i++) begin
        logic [MODE_W-1:0] md;
        logic drive;
        logic active;
        md = cfg.pinMode[i*MODE_W +: MODE_W];
        drive = 1'b0;
        active = 1'b0;
        case (md)
          MODE_OUTPUT: begin
            drive = cfg.outputData[i];
            active = 1'b1;
          end
          MODE_ALTFUNC: begin
            drive = altfuncOut[i*AF_COUNT + int'(cfg.altfuncSelect[i*AF_W +: AF_W])];
            active = 1'b1;
          end
          default: begin
            active = 1'b0;
          end
        endcase
        if (active && cfg.outputType[i] == OTYPE_OPEN_DRAIN) begin
          // open drain only ever pulls low, a high releases the pin
          pinOut[i] <= 1'b0;
          pinOe[i] <= ~drive;
        end else begin
          pinOut[i] <= active & drive;
          pinOe[i] <= active;
        end
      end
    end
  end

  // pull resistors, speed and analog switch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pullUpEn <= 16'h0000;
      pullDownEn <= 16'h0000;
      speedOut <= 32'h0000_0000;
      analogEn <= 16'h0000;
    end else begin
      for (int i = 0; i < PIN_COUNT; i++) begin
        logic [MODE_W-1:0] md;
        logic [1:0] pl;
        md = cfg.pinMode[i*MODE_W +: MODE_W];
        pl = cfg.pullSelect[2*i +: 2];
        // reserved code 3 falls to no pull in every mode; analog never pulls
        pullUpEn[i] <= (md != MODE_ANALOG) && (pl == PULL_UP);
        pullDownEn[i] <= (md != MODE_ANALOG) && (pl == PULL_DOWN);
        if (md == MODE_OUTPUT || md == MODE_ALTFUNC) begin
          speedOut[2*i +: 2] <= cfg.outputSpeed[2*i +: 2];
        end else begin
          speedOut[2*i +: 2] <= 2'h0;
        end
        analogEn[i] <= (md == MODE_ANALOG);
      end
    end
  end

endmodule

// ### bench/gp_pins_model.sv
/*
  gp_pins_model: the package pins seen from outside: resolves each pin wire from
  device drive, an outside driver and the weak pulls. assumes one clock.
*/
`timescale 1ns/1ps
module gp_pins_model
  import gp_pkg::*;
(
  input wire logic clk,
  input wire logic [PIN_COUNT-1:0] pinOut,
  input wire logic [PIN_COUNT-1:0] pinOe,
  input wire logic [PIN_COUNT-1:0] pullUpEn,
  input wire logic [PIN_COUNT-1:0] pullDownEn,
  input wire logic [PIN_COUNT-1:0] extEn,
  input wire logic [PIN_COUNT-1:0] extVal,
  output logic [PIN_COUNT-1:0] pinIn
);
  logic [PIN_COUNT-1:0] noise = 16'h0000;
  // an undriven, unpulled pin wanders so a floating level never looks settled
  always @(posedge clk) begin
    noise <= ~noise;
  end
  // device drive wins, then the outside driver, then the weak pulls
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (pinOe[i]) pinIn[i] = pinOut[i];
      else if (extEn[i]) pinIn[i] = extVal[i];
      else if (pullUpEn[i]) pinIn[i] = 1'b1;
      else if (pullDownEn[i]) pinIn[i] = 1'b0;
      else pinIn[i] = noise[i];
    end
  end
endmodule

// ### bench/gp_port_assertions.sv
/*
  gp_port_assertions: timing checks on the port's pins and register port.
  assumes it is bound into gp_port and sees only its ports.
*/
`timescale 1ns/1ps
module gp_port_assertions
  import gp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [31:0] rdData,
  input wire logic [PIN_COUNT-1:0] pinIn,
  input wire logic [PIN_COUNT-1:0] pinOut,
  input wire logic [PIN_COUNT-1:0] pinOe,
  input wire logic [PIN_COUNT-1:0] pullUpEn,
  input wire logic [PIN_COUNT-1:0] pullDownEn,
  input wire logic [31:0] speedOut,
  input wire logic [PIN_COUNT-1:0] analogEn,
  input wire logic [PIN_COUNT*AF_COUNT-1:0] altfuncOut,
  input wire logic [PIN_COUNT*AF_COUNT-1:0] altfuncIn,
  input wire logic configLocked
);
  logic [1:0] upCnt;
  logic [PIN_COUNT-1:0] afAny;
  logic [PIN_COUNT-1:0] afMany;
  logic [31:0] anaMask;
  // edges since reset, saturating: the input synchroniser needs time to fill
  always_ff @(posedge clk or posedge rst) begin
    if (rst) upCnt <= 2'h0;
    else if (upCnt != 2'h3) upCnt <= upCnt + 2'h1;
  end
  // per-pin views of the function channels and the speed lanes
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      afAny[i] = |altfuncIn[i*AF_COUNT +: AF_COUNT];
      afMany[i] = !$onehot0(altfuncIn[i*AF_COUNT +: AF_COUNT]);
      anaMask[2*i +: 2] = {2{analogEn[i]}};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_rd_quiet;
    !$past(rdEn) |-> rdData == 32'h0000_0000;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("rdData outside read slot");
  property p_pull_excl;
    (pullUpEn & pullDownEn) == 16'h0000;
  endproperty
  a_pull_excl: assert property (p_pull_excl) else $error("both pulls on");
  property p_analog_off;
    (analogEn & (pinOe | pullUpEn | pullDownEn)) == 16'h0000;
  endproperty
  a_analog_off: assert property (p_analog_off) else $error("analog pin driven");
  property p_speed_ign;
    (speedOut & anaMask) == 32'h0000_0000;
  endproperty
  a_speed_ign: assert property (p_speed_ign) else $error("speed on analog pin");
  property p_af_one;
    afMany == 16'h0000;
  endproperty
  a_af_one: assert property (p_af_one) else $error("two function inputs on a pin");
  property p_lock_hold;
    configLocked |=> configLocked;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock dropped");
  // a pad change needs a write two edges back or a new peripheral value
  property p_pin_cause;
    !$past(wrEn, 2) && $past(altfuncOut) == $past(altfuncOut, 2)
      |-> $stable(pinOut) && $stable(pinOe);
  endproperty
  a_pin_cause: assert property (p_pin_cause) else $error("pin moved uncaused");
  for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
    property p_in_route;
      upCnt == 2'h3 && !analogEn[g] && !$past(analogEn[g]) && !$past(analogEn[g], 2)
        && $past(pinIn[g]) == $past(pinIn[g], 2) && $past(pinIn[g], 2) == $past(pinIn[g], 3)
        |-> $past(afAny[g]) == $past(pinIn[g]);
    endproperty
    a_in_route: assert property (p_in_route) else $error("pin not routed");
  end
  c_read: cover property (rdEn && addr == OFS_INPUT_DATA);
  c_lock: cover property ($rose(configLocked));
  c_analog: cover property (analogEn != 16'h0000);
endmodule

bind gp_port gp_port_assertions gp_port_assertions_i (
  .clk(clk), .rst(rst), .addr(addr), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
  .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pullUpEn(pullUpEn),
  .pullDownEn(pullDownEn), .speedOut(speedOut), .analogEn(analogEn),
  .altfuncOut(altfuncOut), .altfuncIn(altfuncIn), .configLocked(configLocked)
);

// ### bench/gp_port_test.sv
/*
  gp_port_test: register-level run of the port with a pin model outside.
  assumes gp_port, gp_pins_model and the checker are compiled before it.
*/
`timescale 1ns/1ps
module gp_port_test
  import gp_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [31:0] wrData = 32'h0000_0000;
  logic [3:0] wrByteEn = 4'h0;
  logic wrEn = 1'b0;
  logic rdEn = 1'b0;
  logic [PIN_COUNT*AF_COUNT-1:0] altfuncOut = '0;
  logic [PIN_COUNT-1:0] extEn = 16'h0000;
  logic [PIN_COUNT-1:0] extVal = 16'h0000;
  logic [31:0] rdData;
  logic [31:0] speedOut;
  logic [PIN_COUNT-1:0] pinIn, pinOut, pinOe, pullUpEn, pullDownEn, analogEn;
  logic [PIN_COUNT*AF_COUNT-1:0] altfuncIn;
  logic configLocked;
  int errorCnt = 0;
  int checked = 0;
  logic [ADDR_W-1:0] regs [11] = '{OFS_PIN_MODE, OFS_OUTPUT_TYPE, OFS_OUTPUT_SPEED,
    OFS_PULL_SELECT, OFS_OUTPUT_DATA, OFS_BIT_SET_CLEAR, OFS_CONFIG_LOCK, OFS_ALTFUNC_LOW,
    OFS_ALTFUNC_HIGH, OFS_BIT_CLEAR, 8'h2C};

  gp_port gp_port_i (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData),
    .wrByteEn(wrByteEn), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe), .pullUpEn(pullUpEn), .pullDownEn(pullDownEn),
    .speedOut(speedOut), .analogEn(analogEn), .altfuncOut(altfuncOut),
    .altfuncIn(altfuncIn), .configLocked(configLocked));
  gp_pins_model gp_pins_model_i (.clk(clk), .pinOut(pinOut), .pinOe(pinOe),
    .pullUpEn(pullUpEn), .pullDownEn(pullDownEn), .extEn(extEn), .extVal(extVal),
    .pinIn(pinIn));

  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errorCnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // strobe stays high into the next call; back-to-back writes each re-assign it, idle or rd lowers it
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                    input logic [3:0] be = BYTE_EN_WORD);
    @(posedge clk);
    rdEn <= 1'b0;
    wrEn <= 1'b1;
    addr <= a;
    wrData <= d;
    wrByteEn <= be;
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk);
      wrEn <= 1'b0;
      rdEn <= 1'b0;
    end
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string nm,
                    input logic [31:0] m = 32'hFFFF_FFFF);
    @(posedge clk);
    wrEn <= 1'b0;
    rdEn <= 1'b1;
    addr <= a;
    @(posedge clk);
    rdEn <= 1'b0;
    #1 chk(nm, exp, rdData & m);
  endtask
  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic finalReport();
    $display("checks %0d mismatches %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (5000) @(posedge clk);
    errorCnt++;
    finalReport();
  end

  // main sequence: pin0 push-pull out, pin1 open-drain out, pin2 function, pin8/9 in
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wr(8'h2C, 32'hFFFF_FFFF);
    #1 chk("pinOe", 32'h0000_0000, 32'(pinOe));
    foreach (regs[i]) rd(regs[i], 32'h0000_0000, "reset");
    done("reset");
    wr(OFS_PIN_MODE, 32'h0000_0025);
    wr(OFS_OUTPUT_TYPE, 32'hFFFF_0002, 4'h3);
    wr(OFS_PULL_SELECT, 32'h1234_0004, 4'h1);
    wr(OFS_PULL_SELECT, 32'h0008_0000, 4'h4);
    wr(OFS_OUTPUT_DATA, 32'h0000_0003);
    rd(OFS_OUTPUT_TYPE, 32'h0000_0002, "type");
    rd(OFS_PULL_SELECT, 32'h0008_0004, "pull");
    idle(1);
    #1 chk("pinOe", 32'h0000_0005, 32'(pinOe & 16'h0007));
    chk("pinOut", 32'h0000_0001, 32'(pinOut & 16'h0007));
    chk("pullUp", 32'h0000_0002, 32'(pullUpEn));
    chk("pullDown", 32'h0000_0200, 32'(pullDownEn));
    wr(OFS_BIT_SET_CLEAR, 32'h0003_0004);
    wr(OFS_BIT_SET_CLEAR, 32'h0008_0008);
    rd(OFS_OUTPUT_DATA, 32'h0000_000C, "set clear");
    wr(OFS_BIT_CLEAR, 32'h0000_0004);
    rd(OFS_OUTPUT_DATA, 32'h0000_0008, "bit clear");
    idle(1);
    #1 chk("pinOe", 32'h0000_0007, 32'(pinOe & 16'h0007));
    for (int i = 0; i < 8; i++) begin
      wr(OFS_OUTPUT_DATA, 32'(i % 2));
      if (i >= 2) #1 chk("toggle", 32'(i % 2), 32'(pinOut[0]));
    end
    done("drive");
    for (int k = 0; k < AF_COUNT; k++) begin
      wr(OFS_ALTFUNC_LOW, 32'(k) << 8);
      altfuncOut <= type(altfuncOut)'(1'b1) << (2 * AF_COUNT + k);
      idle(5);
      #1 chk("afPin", 32'h0000_0001, 32'(pinOut[2] & pinOe[2]));
      chk("afIn", 32'(16'h0001 << k), 32'(altfuncIn[2*AF_COUNT +: AF_COUNT]));
    end
    rd(OFS_ALTFUNC_LOW, 32'h0000_0F00, "afLow");
    idle(1);
    extEn <= 16'h0100;
    extVal <= 16'h0100;
    idle(4);
    rd(OFS_INPUT_DATA, 32'h0000_0105, "input", 32'h0000_0307);
    wr(OFS_PIN_MODE, 32'h0003_0025);
    wr(OFS_PULL_SELECT, 32'h0008_000C);
    wr(OFS_OUTPUT_SPEED, 32'hFFFF_FFFF);
    idle(4);
    #1 chk("analog", 32'h0000_0100, 32'(analogEn));
    chk("pullUp", 32'h0000_0000, 32'(pullUpEn));
    chk("pullDown", 32'h0000_0200, 32'(pullDownEn));
    chk("speed", 32'h0000_003F, speedOut);
    rd(OFS_INPUT_DATA, 32'h0000_0000, "analogIn", 32'h0000_0100);
    done("config");
    wr(OFS_CONFIG_LOCK, 32'h0001_0005);
    wr(OFS_CONFIG_LOCK, 32'h0000_0005);
    wr(OFS_CONFIG_LOCK, 32'h0000_0005);
    wr(OFS_CONFIG_LOCK, 32'h0001_0005);
    rd(OFS_CONFIG_LOCK, 32'h0000_0000, "lockEarly", 32'h0001_0000);
    wr(OFS_CONFIG_LOCK, 32'h0000_0005);
    wr(OFS_CONFIG_LOCK, 32'h0001_0005);
    wr(OFS_PIN_MODE, 32'h0000_0000);
    wr(OFS_OUTPUT_SPEED, 32'h0000_0000);
    wr(OFS_CONFIG_LOCK, 32'h0000_0000);
    rd(OFS_CONFIG_LOCK, 32'h0001_0005, "lock");
    rd(OFS_PIN_MODE, 32'h0000_0021, "lockedMode");
    rd(OFS_OUTPUT_SPEED, 32'h0000_0033, "lockedSpeed");
    chk("locked", 32'h0000_0001, 32'(configLocked));
    done("lock");
    @(posedge clk) rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    #1 chk("unlocked", 32'h0000_0000, 32'(configLocked));
    chk("pinOe", 32'h0000_0000, 32'(pinOe));
    rd(OFS_PIN_MODE, 32'h0000_0000, "mode");
    done("reset again");
    finalReport();
  end
endmodule
